// *** lsf_flag_unit.sv ***
// Purpose: Link and point-to-point status flags behind a Wishbone slave
// Assumes: Engines report per-word block bits and service completions
// Notes:   One-cycle ack latency; flag areas are read only
// Notes on behaviour
// - Normal flag sets when stations run clean, blocks good, parameters exchanged.
// - Normal flag stays set until the link is disabled.
// - Trouble rises while normal if a configured block goes bad.
// - Trouble clears once all configured blocks are good again.
// - Block state is run AND comm good AND NOT station error.
// - One station-run bit per block.
// - One communication-good bit per block.
// - One station-error bit per block.
// - One block-configured bit per block.
// - Links 1 to 12, each area based at 500 times link minus one.
// - Sixteen blocks per word, lowest block in bit 0, eight words.
// - Service flags exist for parameters 1 to 8, blocks 0 to 63.
// - Done-ok bit sets on a normal service end.
// - Done-fail bit sets on an abnormal service end.
// - Abnormal end holds a word-wide error code.
// - Double-word count of normal completions per parameter and block.
// - Double-word count of abnormal completions per parameter and block.
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lsf_flag_unit #(
  parameter int NUM_LINKS  = lsf_pkg::NUM_LINKS,
  parameter int P2P_PARAMS = lsf_pkg::P2P_PARAMS,
  parameter int P2P_BLOCKS = lsf_pkg::P2P_BLOCKS
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [15:0]            wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   linkUpdValid,
  input  wire logic [3:0]             linkUpdLink,
  input  wire logic [2:0]             linkUpdWord,
  input  wire logic [15:0]            linkUpdRun,
  input  wire logic [15:0]            linkUpdOk,
  input  wire logic [15:0]            linkUpdErr,
  input  wire logic [15:0]            linkUpdCfg,
  input  wire logic [NUM_LINKS-1:0]   linkParamOk,
  input  wire logic [NUM_LINKS-1:0]   linkEnable,
  input  wire logic                   svcDoneValid,
  input  wire logic [2:0]             svcParam,
  input  wire logic [5:0]             svcBlock,
  input  wire logic                   svcFail,
  input  wire logic [15:0]            svcErrCode,
  output logic      [NUM_LINKS-1:0]   allStationNormal,
  output logic      [NUM_LINKS-1:0]   linkTrouble,
  output logic                        irq
);
  localparam int MEM_N  = NUM_LINKS * lsf_pkg::ARR_WORDS;
  localparam int SVC_N  = P2P_PARAMS * P2P_BLOCKS;
  localparam int IRQ_W  = 2 * NUM_LINKS;
  localparam int FW     = lsf_pkg::FLAG_W;
  localparam int IW     = lsf_pkg::IDX_W;

  // ==========================================================
  // Storage
  logic [FW-1:0]                 runMem  [MEM_N];
  logic [FW-1:0]                 okMem   [MEM_N];
  logic [FW-1:0]                 errMem  [MEM_N];
  logic [FW-1:0]                 cfgMem  [MEM_N];
  logic                          doneOkMem   [SVC_N];
  logic                          doneFailMem [SVC_N];
  logic [lsf_pkg::CODE_W-1:0]    codeMem     [SVC_N];
  logic [lsf_pkg::CNT_W-1:0]     okCntMem    [SVC_N];
  logic [lsf_pkg::CNT_W-1:0]     failCntMem  [SVC_N];

  logic [IRQ_W-1:0]              irqStatus_reg;
  logic [IRQ_W-1:0]              irqMask_reg;
  logic [IRQ_W-1:0]              irqEvent;
  logic [NUM_LINKS-1:0]          asnRise;
  logic [NUM_LINKS-1:0]          troubleRise;

  logic [6:0]                    updIdx;
  logic                          updGood;
  logic [8:0]                    svcIdx;

  logic [IW-1:0]                 wordIdx;
  logic [IW-1:0]                 linkSelW;
  logic [IW-1:0]                 linkOfs;
  logic [IW-1:0]                 p2pRel;
  logic [6:0]                    rdMemIdx;
  logic [8:0]                    rdSvcIdx;
  logic [FW-1:0]                 rdRun;
  logic [FW-1:0]                 rdOk;
  logic [FW-1:0]                 rdErr;
  logic [31:0]                   rdData;
  logic                          busReq;
  logic                          busWrite;

  // ==========================================================
  // Link block arrays, written word by word by the link engines
  assign updIdx  = 7'(linkUpdLink * lsf_pkg::ARR_WORDS) + 7'(linkUpdWord);
  // A word is healthy when every configured block in it runs clean
  assign updGood = &(~linkUpdCfg | (linkUpdRun & linkUpdOk & ~linkUpdErr));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_N; i++) begin
        runMem[i] <= '0;
        okMem[i]  <= '0;
        errMem[i] <= '0;
        cfgMem[i] <= '0;
      end
    end else if (linkUpdValid && (int'(linkUpdLink) < NUM_LINKS)) begin
      runMem[updIdx] <= linkUpdRun;
      okMem[updIdx]  <= linkUpdOk;
      errMem[updIdx] <= linkUpdErr;
      cfgMem[updIdx] <= linkUpdCfg;
    end
  end

  // ==========================================================
  // Per-link normal and trouble flags
  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : gLink
      lsf_link_flag #(
        .ARR_WORDS        (lsf_pkg::ARR_WORDS)
      ) uFlag (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .updValid         (linkUpdValid && (int'(linkUpdLink) == g)),
        .updWord          (linkUpdWord),
        .updGood          (updGood),
        .paramOk          (linkParamOk[g]),
        .linkEnable       (linkEnable[g]),
        .allStationNormal (allStationNormal[g]),
        .linkTrouble      (linkTrouble[g]),
        .asnRise          (asnRise[g]),
        .troubleRise      (troubleRise[g])
      );
    end
  endgenerate

  // ==========================================================
  // Point-to-point service results
  assign svcIdx = 9'(svcParam * P2P_BLOCKS) + 9'(svcBlock);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SVC_N; i++) begin
        doneOkMem[i]   <= 1'b0;
        doneFailMem[i] <= 1'b0;
        codeMem[i]     <= '0;
        okCntMem[i]    <= '0;
        failCntMem[i]  <= '0;
      end
    end else if (svcDoneValid) begin
      // Latest end wins; the other done bit is dropped
      doneOkMem[svcIdx]   <= !svcFail;
      doneFailMem[svcIdx] <= svcFail;
      if (svcFail) begin
        codeMem[svcIdx]    <= svcErrCode;
        // Natural 32-bit wrap after all ones
        failCntMem[svcIdx] <= failCntMem[svcIdx] + 32'h00000001;
      end else begin
        okCntMem[svcIdx]   <= okCntMem[svcIdx] + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  assign irqEvent = {troubleRise, asnRise};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_reg <= '0;
    end else begin
      // New events win over a write-one clear in the same cycle
      for (int b = 0; b < IRQ_W; b++) begin
        if (irqEvent[b]) begin
          irqStatus_reg[b] <= 1'b1;
        end else if (busWrite && wordIdx == lsf_pkg::IRQ_STATUS && wb_sel_i[b / 8]
                     && wb_dat_i[b]) begin
          irqStatus_reg[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask_reg <= '0;
    end else if (busWrite && wordIdx == lsf_pkg::IRQ_MASK) begin
      for (int b = 0; b < IRQ_W; b++) begin
        if (wb_sel_i[b / 8]) begin
          irqMask_reg[b] <= wb_dat_i[b];
        end
      end
    end
  end

  assign irq = |(irqStatus_reg & irqMask_reg);

  // ==========================================================
  // Bus decode; division by the link area is a constant divisor
  assign wordIdx  = wb_adr_i[15:2];
  assign linkSelW = wordIdx / lsf_pkg::LINK_AREA;
  assign linkOfs  = wordIdx - IW'(linkSelW * lsf_pkg::LINK_AREA);
  assign p2pRel   = wordIdx - lsf_pkg::P2P_BASE;
  assign rdSvcIdx = p2pRel[10:2];

  always_comb begin
    rdMemIdx = '0;
    if (linkOfs >= lsf_pkg::OFS_STATE && linkOfs < lsf_pkg::OFS_RUN) begin
      rdMemIdx = 7'(linkSelW * lsf_pkg::ARR_WORDS) + 7'(linkOfs - lsf_pkg::OFS_STATE);
    end else if (linkOfs >= lsf_pkg::OFS_RUN && linkOfs < lsf_pkg::OFS_OK) begin
      rdMemIdx = 7'(linkSelW * lsf_pkg::ARR_WORDS) + 7'(linkOfs - lsf_pkg::OFS_RUN);
    end else if (linkOfs >= lsf_pkg::OFS_OK && linkOfs < lsf_pkg::OFS_ERR) begin
      rdMemIdx = 7'(linkSelW * lsf_pkg::ARR_WORDS) + 7'(linkOfs - lsf_pkg::OFS_OK);
    end else if (linkOfs >= lsf_pkg::OFS_ERR && linkOfs < lsf_pkg::OFS_CFG) begin
      rdMemIdx = 7'(linkSelW * lsf_pkg::ARR_WORDS) + 7'(linkOfs - lsf_pkg::OFS_ERR);
    end else if (linkOfs >= lsf_pkg::OFS_CFG
                 && linkOfs < lsf_pkg::OFS_CFG + lsf_pkg::ARR_LEN) begin
      rdMemIdx = 7'(linkSelW * lsf_pkg::ARR_WORDS) + 7'(linkOfs - lsf_pkg::OFS_CFG);
    end
  end

  assign rdRun = runMem[rdMemIdx];
  assign rdOk  = okMem[rdMemIdx];
  assign rdErr = errMem[rdMemIdx];

  // ==========================================================
  // Read data; unmapped words read as zero
  always_comb begin
    rdData = '0;
    if (wordIdx < lsf_pkg::LINK_SPAN) begin
      if (linkOfs == lsf_pkg::OFS_FLAGS) begin
        rdData[lsf_pkg::BIT_ASN] = allStationNormal[linkSelW[3:0]];
        rdData[lsf_pkg::BIT_TRB] = linkTrouble[linkSelW[3:0]];
      end else if (linkOfs >= lsf_pkg::OFS_STATE && linkOfs < lsf_pkg::OFS_RUN) begin
        // Lowest block of each word sits in bit 0
        rdData[FW-1:0] = rdRun & rdOk & ~rdErr;
      end else if (linkOfs >= lsf_pkg::OFS_RUN && linkOfs < lsf_pkg::OFS_OK) begin
        rdData[FW-1:0] = rdRun;
      end else if (linkOfs >= lsf_pkg::OFS_OK && linkOfs < lsf_pkg::OFS_ERR) begin
        rdData[FW-1:0] = rdOk;
      end else if (linkOfs >= lsf_pkg::OFS_ERR && linkOfs < lsf_pkg::OFS_CFG) begin
        rdData[FW-1:0] = rdErr;
      end else if (linkOfs >= lsf_pkg::OFS_CFG
                   && linkOfs < lsf_pkg::OFS_CFG + lsf_pkg::ARR_LEN) begin
        rdData[FW-1:0] = cfgMem[rdMemIdx];
      end
    end else if (wordIdx == lsf_pkg::IRQ_STATUS) begin
      rdData[IRQ_W-1:0] = irqStatus_reg;
    end else if (wordIdx == lsf_pkg::IRQ_MASK) begin
      rdData[IRQ_W-1:0] = irqMask_reg;
    end else if (wordIdx >= lsf_pkg::P2P_BASE
                 && wordIdx < lsf_pkg::P2P_BASE + lsf_pkg::P2P_SPAN) begin
      unique case (p2pRel[1:0])
        lsf_pkg::P2P_F_FLAGS: begin
          rdData[lsf_pkg::BIT_DONE_OK]   = doneOkMem[rdSvcIdx];
          rdData[lsf_pkg::BIT_DONE_FAIL] = doneFailMem[rdSvcIdx];
        end
        lsf_pkg::P2P_F_CODE: begin
          rdData[lsf_pkg::CODE_W-1:0] = codeMem[rdSvcIdx];
        end
        lsf_pkg::P2P_F_OKCNT: begin
          rdData = okCntMem[rdSvcIdx];
        end
        lsf_pkg::P2P_F_FLCNT: begin
          rdData = failCntMem[rdSvcIdx];
        end
      endcase
    end
  end

  // ==========================================================
  // Wishbone handshake: ack one cycle after the request, then drop
  assign busReq   = wb_cyc_i && wb_stb_i;
  // Writes act at the edge where the master sees ack
  assign busWrite = busReq && wb_we_i && wb_ack_o;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq && !wb_ack_o;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (busReq && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rdData;
    end
  end
endmodule
`default_nettype wire

// *** lsf_pkg.sv ***
// Purpose: Shared constants of the link status flag unit
// Assumes: 32-bit classic Wishbone, one word per 16-bit flag word
// Notes:   Word indices below are multiplied by four for byte addresses
`default_nettype none
package lsf_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_LINKS   = 12;
  localparam int BLOCKS      = 128;
  localparam int FLAG_W      = 16;
  localparam int ARR_WORDS   = 8;
  localparam int P2P_PARAMS  = 8;
  localparam int P2P_BLOCKS  = 64;
  localparam int CODE_W      = 16;
  localparam int CNT_W       = 32;
  localparam int IDX_W       = 14;

  // ==========================================================
  // Link area layout, in word indices
  localparam logic [IDX_W-1:0] LINK_AREA = 14'h01F4;
  localparam logic [IDX_W-1:0] LINK_SPAN = 14'h1770;
  localparam logic [IDX_W-1:0] OFS_FLAGS = 14'h0000;
  localparam logic [IDX_W-1:0] OFS_STATE = 14'h0002;
  localparam logic [IDX_W-1:0] OFS_RUN   = 14'h000A;
  localparam logic [IDX_W-1:0] OFS_OK    = 14'h0012;
  localparam logic [IDX_W-1:0] OFS_ERR   = 14'h001A;
  localparam logic [IDX_W-1:0] OFS_CFG   = 14'h0022;
  localparam logic [IDX_W-1:0] ARR_LEN   = 14'h0008;
  localparam int BIT_ASN = 0;
  localparam int BIT_TRB = 1;

  // ==========================================================
  // Interrupt registers and point-to-point area
  localparam logic [IDX_W-1:0] IRQ_STATUS = 14'h1780;
  localparam logic [IDX_W-1:0] IRQ_MASK   = 14'h1781;
  localparam logic [IDX_W-1:0] P2P_BASE   = 14'h1800;
  localparam logic [IDX_W-1:0] P2P_SPAN   = 14'h0800;
  localparam logic [1:0] P2P_F_FLAGS = 2'h0;
  localparam logic [1:0] P2P_F_CODE  = 2'h1;
  localparam logic [1:0] P2P_F_OKCNT = 2'h2;
  localparam logic [1:0] P2P_F_FLCNT = 2'h3;
  localparam int BIT_DONE_OK   = 0;
  localparam int BIT_DONE_FAIL = 1;
endpackage
`default_nettype wire

// *** lsf_link_flag.sv ***
// Purpose: Normal and trouble flags of one cyclic link
// Assumes: Block words are checked as they are written
// Notes:   Good vector starts all ones since nothing is configured
`timescale 1ns/1ps
`default_nettype none
module lsf_link_flag #(
  parameter int ARR_WORDS = 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 updValid,
  input  wire logic [2:0]           updWord,
  input  wire logic                 updGood,
  input  wire logic                 paramOk,
  input  wire logic                 linkEnable,
  output logic                      allStationNormal,
  output logic                      linkTrouble,
  output logic                      asnRise,
  output logic                      troubleRise
);
  logic [ARR_WORDS-1:0] goodReg;
  logic                 allGood;
  logic                 asnNext;
  logic                 troubleNext;

  // ==========================================================
  // Per-word health of configured blocks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      goodReg <= '1;
    end else if (updValid) begin
      goodReg[updWord] <= updGood;
    end
  end

  assign allGood = &goodReg;

  // ==========================================================
  // Normal flag latches until the link is stopped
  always_comb begin
    asnNext = allStationNormal;
    if (!linkEnable) begin
      asnNext = 1'b0;
    end else if (allGood && paramOk) begin
      asnNext = 1'b1;
    end
    troubleNext = asnNext && !allGood;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      allStationNormal <= 1'b0;
      linkTrouble      <= 1'b0;
    end else begin
      allStationNormal <= asnNext;
      linkTrouble      <= troubleNext;
    end
  end

  assign asnRise     = asnNext && !allStationNormal;
  assign troubleRise = troubleNext && !linkTrouble;
endmodule
`default_nettype wire

// *** lsf_flag_unit_monitor.sv ***
// Purpose: Port-level checks of the link status flag unit
// Assumes: One clock, asynchronous active-low reset
// Notes:   Link 1 stands for all links, to keep the checks short
`timescale 1ns/1ps
`default_nettype none
module lsf_flag_unit_monitor #(
  parameter int NUM_LINKS = 12
) (
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [15:0]          wb_adr_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [NUM_LINKS-1:0] linkParamOk,
  input wire logic [NUM_LINKS-1:0] linkEnable,
  input wire logic [NUM_LINKS-1:0] allStationNormal,
  input wire logic [NUM_LINKS-1:0] linkTrouble,
  input wire logic                 irq
);
  // ==========================================================
  // Bus handshake and read data
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  property p_ackLate;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ackLate: assert property (p_ackLate) else $error("ack late");
  property p_ackCause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[15:2] == 14'h1790
      |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upperZero;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[15:2] < 14'h1770
      |=> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("flag word upper half set");
  // ==========================================================
  // Normal and trouble flags of link 1
  property p_hold;
    allStationNormal[0] && linkEnable[0] |=> allStationNormal[0];
  endproperty
  a_hold: assert property (p_hold) else $error("normal flag dropped");
  property p_stop;
    !linkEnable[0] |=> !allStationNormal[0];
  endproperty
  a_stop: assert property (p_stop) else $error("normal flag kept while stopped");
  property p_stopTrb;
    !linkEnable[0] [*2] |=> !linkTrouble[0];
  endproperty
  a_stopTrb: assert property (p_stopTrb) else $error("trouble kept while stopped");
  property p_paramGate;
    !linkParamOk[0] && !allStationNormal[0] |=> !allStationNormal[0];
  endproperty
  a_paramGate: assert property (p_paramGate) else $error("normal without settings");
  property p_trbNeedsAsn;
    linkTrouble[0] |-> allStationNormal[0] || $past(allStationNormal[0]);
  endproperty
  a_trbNeedsAsn: assert property (p_trbNeedsAsn) else $error("trouble without normal");
  c_normal: cover property (allStationNormal[0]);
  c_trouble: cover property (linkTrouble[0]);
  c_irq: cover property (irq);
endmodule
bind lsf_flag_unit lsf_flag_unit_monitor #(.NUM_LINKS(NUM_LINKS)) u_mon (.*);
`default_nettype wire

// *** lsf_engine_model.sv ***
// Purpose: Link and service engines feeding the flag unit
// Assumes: Requests are launched just after a rising edge
// Notes:   Link data lines and the service error code show inverted values once a request ends
`timescale 1ns/1ps
`default_nettype none
module lsf_engine_model (
  input  wire logic  core_clk,
  output logic       linkUpdValid,
  output logic [3:0] linkUpdLink,
  output logic [2:0] linkUpdWord,
  output logic [15:0] linkUpdRun,
  output logic [15:0] linkUpdOk,
  output logic [15:0] linkUpdErr,
  output logic [15:0] linkUpdCfg,
  output logic       svcDoneValid,
  output logic [2:0] svcParam,
  output logic [5:0] svcBlock,
  output logic       svcFail,
  output logic [15:0] svcErrCode
);
  initial begin
    {linkUpdValid, linkUpdLink, linkUpdWord} = 8'h00;
    {linkUpdRun, linkUpdOk, linkUpdErr, linkUpdCfg} = 64'h0;
    {svcDoneValid, svcParam, svcBlock, svcFail, svcErrCode} = 27'h0;
  end
  // ==========================================================
  // One word of block bits for one link
  task automatic sendWord(input logic [3:0] l, input logic [2:0] w,
                          input logic [15:0] r, o, e, c);
    @(posedge core_clk);
    linkUpdValid <= 1'b1;
    linkUpdLink <= l;
    linkUpdWord <= w;
    {linkUpdRun, linkUpdOk, linkUpdErr, linkUpdCfg} <= {r, o, e, c};
    @(posedge core_clk);
    linkUpdValid <= 1'b0;
    {linkUpdRun, linkUpdOk, linkUpdErr, linkUpdCfg} <= ~{r, o, e, c};
  endtask
  // ==========================================================
  // n back-to-back completions of one service entry
  task automatic sendSvc(input logic [2:0] p, input logic [5:0] b, input logic f,
                         input logic [15:0] code, input int n);
    @(posedge core_clk);
    {svcDoneValid, svcParam, svcBlock, svcFail, svcErrCode} <= {1'b1, p, b, f, code};
    repeat (n) @(posedge core_clk);
    svcDoneValid <= 1'b0;
    svcErrCode <= ~code;
  endtask
endmodule
`default_nettype wire

// *** test_link_status_flag_unit.sv ***
// Purpose: Self-checking bench of the link status flag unit
// Assumes: Registered one-cycle Wishbone ack
// Notes:   Scenarios run in order and share the flag state
`timescale 1ns/1ps
`default_nettype none
module test_link_status_flag_unit;
  logic        core_clk = 1'b0;
  logic        rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [15:0] wb_adr_i, linkUpdRun, linkUpdOk, linkUpdErr, linkUpdCfg, svcErrCode;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, linkUpdLink;
  logic [2:0]  linkUpdWord, svcParam;
  logic [5:0]  svcBlock;
  logic        linkUpdValid, svcDoneValid, svcFail;
  logic [11:0] linkParamOk, linkEnable, allStationNormal, linkTrouble;
  int          fails, checks;
  lsf_flag_unit dut (.*);
  lsf_engine_model eng (.*);
  always #5 core_clk = ~core_clk;
  // ==========================================================
  // Shared tasks
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [13:0] idx, input logic [31:0] wd,
                    output logic [31:0] rdat);
    int n;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rdChk(input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic flags(input logic asn, input logic trb);
    repeat (3) @(posedge core_clk);
    chk({30'h0, linkTrouble[0], allStationNormal[0]}, {30'h0, trb, asn});
  endtask
  task automatic irqIs(input logic exp);
    @(posedge core_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_link1;
    logic [31:0] d;
    eng.sendWord(4'h0, 3'h3, 16'h0020, 16'h0020, 16'h0000, 16'h0020);
    linkEnable <= 12'h001;
    flags(1'b0, 1'b0);
    linkParamOk <= 12'h001;
    flags(1'b1, 1'b0);
    rdChk(14'h0005, 32'h0020);
    rdChk(14'h000D, 32'h0020);
    rdChk(14'h0015, 32'h0020);
    rdChk(14'h0025, 32'h0020);
    eng.sendWord(4'h0, 3'h3, 16'h0020, 16'h0020, 16'h0020, 16'h0020);
    flags(1'b1, 1'b1);
    rdChk(14'h001D, 32'h0020);
    rdChk(14'h0005, 32'h0000);
    rdChk(14'h0000, 32'h0003);
    linkParamOk <= 12'h000;
    eng.sendWord(4'h0, 3'h3, 16'h0020, 16'h0020, 16'h0000, 16'h0020);
    flags(1'b1, 1'b0);
    eng.sendWord(4'h0, 3'h3, 16'h0000, 16'h0020, 16'h0000, 16'h0020);
    flags(1'b1, 1'b1);
    wb(1'b1, 14'h0000, 32'h0, d);
    linkEnable <= 12'h000;
    flags(1'b0, 1'b0);
    $display("test link1 done");
  endtask
  task automatic t_map;
    logic [31:0] d;
    eng.sendWord(4'hB, 3'h7, 16'h8000, 16'h0000, 16'h0000, 16'h8000);
    eng.sendWord(4'hC, 3'h7, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF);
    rdChk(14'h158D, 32'h8000);
    rdChk(14'h1585, 32'h0000);
    rdChk(14'h15A5, 32'h8000);
    wb(1'b1, 14'h158D, 32'h0000FFFF, d);
    rdChk(14'h158D, 32'h8000);
    rdChk(14'h1790, 32'h0000);
    $display("test map done");
  endtask
  task automatic t_irq;
    logic [31:0] d;
    rdChk(14'h1780, 32'h1001);
    irqIs(1'b0);
    wb(1'b1, 14'h1781, 32'h1, d);
    irqIs(1'b1);
    wb(1'b1, 14'h1780, 32'h1, d);
    irqIs(1'b0);
    wb(1'b1, 14'h1781, 32'h1000, d);
    irqIs(1'b1);
    wb(1'b1, 14'h1780, 32'h1000, d);
    irqIs(1'b0);
    rdChk(14'h1780, 32'h0);
    rdChk(14'h1781, 32'h1000);
    $display("test irq done");
  endtask
  task automatic t_svc;
    eng.sendSvc(3'h7, 6'h3F, 1'b0, 16'h1234, 2);
    rdChk(14'h1FFC, 32'h1);
    rdChk(14'h1FFE, 32'h2);
    eng.sendSvc(3'h7, 6'h3F, 1'b1, 16'hBEEF, 1);
    rdChk(14'h1FFC, 32'h2);
    rdChk(14'h1FFD, 32'hBEEF);
    rdChk(14'h1FFF, 32'h1);
    eng.sendSvc(3'h0, 6'h00, 1'b0, 16'h0000, 1);
    rdChk(14'h1800, 32'h1);
    rdChk(14'h1802, 32'h1);
    rdChk(14'h1FFE, 32'h2);
    rdChk(14'h1FFD, 32'hBEEF);
    $display("test svc done");
  endtask
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i} = {16'h0, 32'h0, 4'hF};
    {linkParamOk, linkEnable, fails, checks} = {24'h0, 32'h0, 32'h0};
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    chk({20'h0, allStationNormal}, 32'h0);
    rdChk(14'h0022, 32'h0);
    t_link1();
    t_map();
    t_irq();
    t_svc();
    give_verdict();
  end
endmodule
`default_nettype wire
